// ==== hdl/bdm_addr_map.v ====
// Effective address resolution for direct and indirect accesses.
`timescale 1ns/100ps
`include "bdm_consts.vh"
module bdm_addr_map (
  input  wire [7:0] addr,
  input  wire [7:0] ptr0,
  input  wire [7:0] ptr1,
  input  wire [2:0] bank_select_field,
  output reg  [7:0] eff_addr,
  output reg  [2:0] eff_bank,
  output reg        via_port
);
  // Ports redirect; direct accesses always use bank 0.
  always @* begin
    eff_addr = addr;
    eff_bank = `BDM_BANK0;
    via_port = 1'b0;
    if (addr == `BDM_ADDR_PORT0) begin
      eff_addr = ptr0;
      eff_bank = `BDM_BANK0;
      via_port = 1'b1;
    end else if (addr == `BDM_ADDR_PORT1) begin
      eff_addr = ptr1;
      eff_bank = bank_select_field;
      via_port = 1'b1;
    end
  end
endmodule // bdm_addr_map

// ==== hdl/bdm_consts.vh ====
// Constants for the banked data memory and indirect addressing unit.
`ifndef BDM_CONSTS_VH
`define BDM_CONSTS_VH
// Special function register addresses inside bank 0.
`define BDM_ADDR_PORT0      8'h00
`define BDM_ADDR_PTR0       8'h01
`define BDM_ADDR_PORT1      8'h02
`define BDM_ADDR_PTR1       8'h03
`define BDM_ADDR_BANKPTR    8'h04
`define BDM_ADDR_ROREG      8'h05
// Bank select codes.
`define BDM_BANK0           3'b000
`define BDM_BANK4           3'b100
`define BDM_BANK5           3'b101
`define BDM_BANK_RESET      3'b000
// Byte values.
`define BDM_ZERO_BYTE       8'h00
`define BDM_PTR_RESET       8'h00
// Operation codes from the core.
`define BDM_OP_BYTE         2'b00
`define BDM_OP_BSET         2'b01
`define BDM_OP_BCLR         2'b10
`define BDM_OP_INCDEC       2'b11
// APB register offsets.
`define BDM_APB_CMD         12'h000
`define BDM_APB_WDATA       12'h004
`define BDM_APB_RDATA       12'h008
`define BDM_APB_BANK        12'h00C
`define BDM_APB_RO          12'h010
`define BDM_APB_PTRS        12'h014
// APB command field positions.
`define BDM_CMD_ADDR_LSB    0
`define BDM_CMD_OP_LSB      8
`define BDM_CMD_BIT_LSB     10
`define BDM_CMD_WR_BIT      13
`define BDM_CMD_DEC_BIT     14
`endif

// ==== hdl/bdm_data_mem.v ====
// Banked data memory decoder with indirect addressing and APB access.
//
// Operation
// - Bank 0 addresses 00H to 7FH decode as special function registers.
// - Bank 0 addresses 80H to FFH decode as 128 bytes of general RAM.
// - Voice data storage sits at 00H to 7FH of banks 4 and 5.
// - Reads of unused special function locations return 00H.
// - Read-only special function registers ignore program writes.
// - General RAM supports byte access and single-bit set and clear.
// - Indirect port accesses go to the address held in its pointer.
// - The first indirect port always resolves to bank 0.
// - The second indirect port resolves to the selected bank.
// - A port as effective target reads 00H and ignores writes.
// - Direct accesses always reach bank 0.
// - Both pointers are real registers, writable and inc/decrementable.
// - The bank pointer holds a three-bit field, upper bits read zero.
// - The bank field resets to 0 except on an idle/sleep watchdog reset.
// - Special function registers are reachable whatever the bank.
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/100ps
`include "bdm_consts.vh"
module bdm_data_mem #(
  parameter GP_DEPTH = 128,
  parameter VD_DEPTH = 128
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        wdt_sleep_reset,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr
);
  // Software-visible state.
  reg  [7:0]  wdata_q;
  reg  [7:0]  rdata_q;
  reg  [7:0]  ro_value_q;
  reg  [7:0]  ptr0_q;
  reg  [7:0]  ptr1_q;
  reg  [2:0]  bank_q;
  reg         keep_bank_q;
  reg  [7:0]  voice_mem [0:2*VD_DEPTH-1];
  wire [7:0]  eff_addr;
  wire [2:0]  eff_bank;
  wire        via_port;
  wire [7:0]  gp_rdata;
  wire        apb_wr;
  wire        apb_rd;
  wire        cmd_go;
  wire [7:0]  cmd_addr;
  wire [1:0]  cmd_op;
  wire [2:0]  cmd_bit;
  wire        cmd_wr;
  wire        cmd_dec;
  wire [7:0]  bit_mask;
  wire        is_sfr;
  wire        is_gp;
  wire        is_voice;
  wire        mem_we;
  reg  [7:0]  old_byte;
  reg  [7:0]  new_byte;
  wire        vd_idx_hi;
  wire [7:0]  vd_idx;

  // The slave answers in the access phase with no wait states.
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign apb_wr  = psel & penable & pwrite;
  assign apb_rd  = psel & ~pwrite;

  // A write to the command word runs one core memory operation.
  assign cmd_go   = apb_wr & (paddr == `BDM_APB_CMD);
  assign cmd_addr = pwdata[`BDM_CMD_ADDR_LSB +: 8];
  assign cmd_op   = pwdata[`BDM_CMD_OP_LSB +: 2];
  assign cmd_bit  = pwdata[`BDM_CMD_BIT_LSB +: 3];
  assign cmd_wr   = pwdata[`BDM_CMD_WR_BIT];
  assign cmd_dec  = pwdata[`BDM_CMD_DEC_BIT];
  assign bit_mask = 8'h01 << cmd_bit;

  bdm_addr_map u_map (
    .addr              (cmd_addr),
    .ptr0              (ptr0_q),
    .ptr1              (ptr1_q),
    .bank_select_field (bank_q),
    .eff_addr          (eff_addr),
    .eff_bank          (eff_bank),
    .via_port          (via_port)
  );

  // Lower half is the register area except where banks 4 and 5 hold voice data; upper half is banked.
  assign is_sfr   = ~eff_addr[7];
  assign is_gp    = eff_addr[7] & (eff_bank == `BDM_BANK0);
  assign is_voice = ~eff_addr[7] & ((eff_bank == `BDM_BANK4) |
                    (eff_bank == `BDM_BANK5)) & via_port;
  assign vd_idx_hi = eff_bank[0];
  assign vd_idx    = {vd_idx_hi, eff_addr[6:0]};

  // Voice data takes precedence for the second port's low half in banks 4
  // and 5; register addresses in other banks still reach the registers.
  always @* begin
    old_byte = `BDM_ZERO_BYTE;
    if (is_voice) begin
      old_byte = voice_mem[vd_idx];
    end else if (is_gp) begin
      old_byte = gp_rdata;
    end else if (is_sfr) begin
      case (eff_addr)
        `BDM_ADDR_PTR0:    old_byte = ptr0_q;
        `BDM_ADDR_PTR1:    old_byte = ptr1_q;
        `BDM_ADDR_BANKPTR: old_byte = {5'b00000, bank_q};
        `BDM_ADDR_ROREG:   old_byte = ro_value_q;
        // Ports themselves and unused slots read zero.
        default:           old_byte = `BDM_ZERO_BYTE;
      endcase
    end else begin
      old_byte = `BDM_ZERO_BYTE;
    end
  end

  // Next value of the target byte for each operation kind.
  always @* begin
    case (cmd_op)
      `BDM_OP_BSET:   new_byte = old_byte | bit_mask;
      `BDM_OP_BCLR:   new_byte = old_byte & ~bit_mask;
      `BDM_OP_INCDEC: new_byte = cmd_dec ? old_byte - 8'h01
                                         : old_byte + 8'h01;
      default:        new_byte = wdata_q;
    endcase
  end

  // Read-only op with wr low just loads the read result.
  assign mem_we = cmd_go & (cmd_wr | (cmd_op != `BDM_OP_BYTE));

  bdm_gp_ram #(
    .DEPTH (GP_DEPTH),
    .AW    (7)
  ) u_gp (
    .pclk     (pclk),
    .we       (mem_we & is_gp & ~is_voice),
    .addr     (eff_addr[6:0]),
    .wdata    (new_byte),
    .bit_mask (bit_mask),
    .bit_mode (1'b0),
    .bit_val  (1'b0),
    .rdata    (gp_rdata)
  );

  // Voice area keeps its contents across reset, like plain RAM.
  always @(posedge pclk) begin
    if (mem_we & is_voice) begin
      voice_mem[vd_idx] <= new_byte;
    end
  end

  // Catch whether this reset must keep the bank field. The flag is taken
  // while running and held through reset only while it stays high, so a
  // plain reset with the flag low always clears the field. An asynchronous
  // clear here would wipe the very flag that must survive the reset.
  always @(posedge pclk) begin
    if (presetn) begin
      keep_bank_q <= wdt_sleep_reset;
    end else begin
      keep_bank_q <= keep_bank_q & wdt_sleep_reset;
    end
  end

  // Bank field survives a watchdog reset from idle or sleep.
  always @(posedge pclk) begin
    if (!presetn && !keep_bank_q) begin
      bank_q <= `BDM_BANK_RESET;
    end else if (presetn && mem_we && is_sfr && !is_voice &&
                 eff_addr == `BDM_ADDR_BANKPTR) begin
      bank_q <= new_byte[2:0];
    end
  end

  // Pointers and software registers.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr0_q     <= `BDM_PTR_RESET;
      ptr1_q     <= `BDM_PTR_RESET;
      wdata_q    <= `BDM_ZERO_BYTE;
      rdata_q    <= `BDM_ZERO_BYTE;
      ro_value_q <= `BDM_ZERO_BYTE;
    end else begin
      if (apb_wr && paddr == `BDM_APB_WDATA) begin
        wdata_q <= pwdata[7:0];
      end
      if (apb_wr && paddr == `BDM_APB_RO) begin
        ro_value_q <= pwdata[7:0];
      end
      if (cmd_go) begin
        rdata_q <= old_byte;
      end
      if (mem_we && is_sfr && !is_voice) begin
        if (eff_addr == `BDM_ADDR_PTR0) begin
          ptr0_q <= new_byte;
        end
        if (eff_addr == `BDM_ADDR_PTR1) begin
          ptr1_q <= new_byte;
        end
        // The read-only register has no write path from the core side.
      end
    end
  end

  // APB read mux; unmapped offsets read zero.
  always @* begin
    prdata = 32'h0000_0000;
    if (apb_rd) begin
      case (paddr)
        `BDM_APB_WDATA: prdata = {24'h00_0000, wdata_q};
        `BDM_APB_RDATA: prdata = {24'h00_0000, rdata_q};
        `BDM_APB_BANK:  prdata = {29'h0000_0000, bank_q};
        `BDM_APB_RO:    prdata = {24'h00_0000, ro_value_q};
        `BDM_APB_PTRS:  prdata = {16'h0000, ptr1_q, ptr0_q};
        default:        prdata = 32'h0000_0000;
      endcase
    end
  end
endmodule // bdm_data_mem

// ==== hdl/bdm_gp_ram.v ====
// General purpose byte RAM with byte write and single-bit set and clear.
`timescale 1ns/100ps
module bdm_gp_ram #(
  parameter DEPTH = 128,
  parameter AW    = 7
) (
  input  wire          pclk,
  input  wire          we,
  input  wire [AW-1:0] addr,
  input  wire [7:0]    wdata,
  input  wire [7:0]    bit_mask,
  input  wire          bit_mode,
  input  wire          bit_val,
  output wire [7:0]    rdata
);
  reg [7:0] mem [0:DEPTH-1];
  // Read is asynchronous so the modify step sees the current byte.
  assign rdata = mem[addr];
  // Bit operations only touch the masked bit; the rest are written back.
  always @(posedge pclk) begin
    if (we) begin
      if (bit_mode) begin
        mem[addr] <= bit_val ? (mem[addr] | bit_mask)
                             : (mem[addr] & ~bit_mask);
      end else begin
        mem[addr] <= wdata;
      end
    end
  end
endmodule // bdm_gp_ram

// ==== sim/bdm_core_model.sv ====
// APB master standing in for the core datapath that issues accesses.
`timescale 1ns/100ps
module bdm_core_model (
  input  wire         pclk,
  input  wire         pready,
  input  wire  [31:0] prdata,
  output logic        psel,
  output logic        penable,
  output logic        pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata
);
  // Bus idles low until the first request.
  initial {psel, penable, pwrite, paddr, pwdata} = '0;

  // One whole transfer; the request is held until pready is seen high.
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    {psel, penable} <= 2'b00;
  endtask
endmodule // bdm_core_model

// ==== sim/bdm_data_mem_bench.sv ====
// Self-checking bench for the banked data memory decoder.
`timescale 1ns/100ps
`include "bdm_consts.vh"
module bdm_data_mem_bench;
  logic        pclk = 1'b0, presetn = 1'b0, wdt_sleep_reset = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  int          errors = 0, checks_done = 0, cycles = 0;

  // Clock at 100 MHz.
  always #5 pclk = ~pclk;

  bdm_data_mem DUT (.pclk(pclk), .presetn(presetn),
    .wdt_sleep_reset(wdt_sleep_reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  bdm_core_model core (.pclk(pclk), .pready(pready), .prdata(prdata),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata));

  task automatic end_of_test;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // A hung wait would otherwise stall the run forever.
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      end_of_test();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask

  // Core operation: byte, bit set, bit clear or pointer step.
  task automatic cmd(input logic [7:0] a, input logic [1:0] op,
    input logic [2:0] b, input logic w, dec, input logic [7:0] d);
    core.xfer(1'b1, `BDM_APB_WDATA, {24'h00_0000, d}, q);
    core.xfer(1'b1, `BDM_APB_CMD, {17'h0, dec, w, b, op, a}, q);
  endtask
  task automatic put(input logic [7:0] a, d);
    cmd(a, `BDM_OP_BYTE, 3'h0, 1'b1, 1'b0, d);
  endtask
  task automatic expect8(input string what, input logic [7:0] a, e);
    cmd(a, `BDM_OP_BYTE, 3'h0, 1'b0, 1'b0, 8'h00);
    core.xfer(1'b0, `BDM_APB_RDATA, 32'h0000_0000, q);
    check(what, q, {24'h00_0000, e});
  endtask
  task automatic apb_chk(input string what, input logic [11:0] a,
                         input logic [31:0] e);
    core.xfer(1'b0, a, 32'h0000_0000, q);
    check(what, q, e);
  endtask

  // Reset with the watchdog sleep flag held at k throughout.
  task automatic do_reset(input logic k);
    @(posedge pclk);
    wdt_sleep_reset <= k;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    wdt_sleep_reset <= 1'b0;
  endtask

  task automatic t_gp;
    put(8'h80, 8'hA5);
    put(8'hFF, 8'h3C);
    expect8("gp 80", 8'h80, 8'hA5);
    expect8("gp ff", 8'hFF, 8'h3C);
    cmd(8'h80, `BDM_OP_BSET, 3'h1, 1'b0, 1'b0, 8'h00);
    cmd(8'h80, `BDM_OP_BCLR, 3'h0, 1'b0, 1'b0, 8'h00);
    expect8("gp bits", 8'h80, 8'hA6);
    expect8("sfr unused", 8'h10, 8'h00);
    core.xfer(1'b1, `BDM_APB_RO, 32'h0000_0033, q);
    put(`BDM_ADDR_ROREG, 8'hCC);
    expect8("ro reg", `BDM_ADDR_ROREG, 8'h33);
  endtask

  task automatic t_ptr;
    put(`BDM_ADDR_PTR0, 8'h80);
    put(`BDM_ADDR_BANKPTR, 8'h04);
    put(`BDM_ADDR_PORT0, 8'h11);
    expect8("port0 bank0", 8'h80, 8'h11);
    cmd(`BDM_ADDR_PTR0, `BDM_OP_INCDEC, 3'h0, 1'b0, 1'b0, 8'h00);
    apb_chk("ptr inc", `BDM_APB_PTRS, 32'h0000_0081);
    cmd(`BDM_ADDR_PTR0, `BDM_OP_INCDEC, 3'h0, 1'b0, 1'b1, 8'h00);
    apb_chk("ptr dec", `BDM_APB_PTRS, 32'h0000_0080);
    put(`BDM_ADDR_PTR0, `BDM_ADDR_PORT0);
    expect8("port self", `BDM_ADDR_PORT0, 8'h00);
  endtask

  task automatic t_bank;
    put(`BDM_ADDR_PTR1, 8'h10);
    put(`BDM_ADDR_PORT1, 8'h44);
    put(`BDM_ADDR_BANKPTR, 8'hFD);
    apb_chk("bank field", `BDM_APB_BANK, 32'h0000_0005);
    put(`BDM_ADDR_PORT1, 8'h55);
    expect8("bank5 voice", `BDM_ADDR_PORT1, 8'h55);
    put(`BDM_ADDR_BANKPTR, 8'h04);
    expect8("bank4 voice", `BDM_ADDR_PORT1, 8'h44);
    expect8("direct 10", 8'h10, 8'h00);
    // Banks 4 and 5 give their low half to voice data, so the register
    // view through the second port is checked from an undefined bank.
    put(`BDM_ADDR_PTR0, 8'h5A);
    put(`BDM_ADDR_BANKPTR, 8'h07);
    put(`BDM_ADDR_PTR1, `BDM_ADDR_PTR0);
    expect8("sfr any bank", `BDM_ADDR_PORT1, 8'h5A);
    put(`BDM_ADDR_PTR1, 8'h80);
    put(`BDM_ADDR_PORT1, 8'h99);
    expect8("undef bank", `BDM_ADDR_PORT1, 8'h00);
    expect8("gp kept", 8'h80, 8'h11);
  endtask

  task automatic t_reset;
    put(`BDM_ADDR_BANKPTR, 8'h04);
    do_reset(1'b1);
    apb_chk("bank kept", `BDM_APB_BANK, 32'h0000_0004);
    do_reset(1'b0);
    apb_chk("bank clear", `BDM_APB_BANK, 32'h0000_0000);
    apb_chk("ptr reset", `BDM_APB_PTRS, 32'h0000_0000);
    put(`BDM_ADDR_PTR1, 8'h80);
    expect8("bank0 port1", `BDM_ADDR_PORT1, 8'h11);
  endtask

  // Main sequence.
  initial begin
    do_reset(1'b0);
    t_gp();
    t_ptr();
    t_bank();
    t_reset();
    end_of_test();
  end
endmodule // bdm_data_mem_bench

// ==== sim/bdm_data_mem_chk.sv ====
// Port assertions for the banked data memory decoder.
`timescale 1ns/100ps
`include "bdm_consts.vh"
module bdm_data_mem_chk (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // A read request in either phase.
  wire rd = psel && !pwrite;

  a_ready_high: assert property (psel && penable |-> pready)
    else $error("pready low in access phase");
  a_no_error: assert property (psel |-> !pslverr)
    else $error("pslverr raised");
  a_bank_upper: assert property (rd && paddr == `BDM_APB_BANK
    |-> prdata[31:3] == 0) else $error("bank upper bits set");
  a_byte_wide: assert property (rd && paddr == `BDM_APB_RDATA
    |-> prdata[31:8] == 0) else $error("read byte too wide");
  a_ro_wide: assert property (rd && paddr == `BDM_APB_RO
    |-> prdata[31:8] == 0) else $error("ro value too wide");
  a_ptr_wide: assert property (rd && paddr == `BDM_APB_PTRS
    |-> prdata[31:16] == 0) else $error("pointer word too wide");
  a_unmapped_zero: assert property (rd && (paddr > `BDM_APB_PTRS ||
    paddr[1:0] != 0) |-> prdata == 0) else $error("unmapped nonzero");
  a_read_steady: assert property (rd && !penable |=> $stable(prdata))
    else $error("read data moved in access phase");

  c_cmd: cover property (psel && penable && pwrite && paddr == 0);
  c_bank: cover property (rd && penable && paddr == `BDM_APB_BANK);
  c_rdata: cover property (rd && penable && paddr == `BDM_APB_RDATA);
endmodule // bdm_data_mem_chk

bind bdm_data_mem bdm_data_mem_chk chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr));
